// ==== hdl/bfr_consts.svh ====
`ifndef BFR_CONSTS_SVH
`define BFR_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define BFR_REG_CTRL 4'h0
`define BFR_REG_STAT 4'h4
`define BFR_REG_REV 4'h8

// Register fields and reset values
`define BFR_CTRL_EN 0
`define BFR_STAT_BUSY 0
`define BFR_STAT_REVERR 1
`define BFR_CTRL_RST 1'b1

// Fault status word bit positions
`define BFR_SSW_TP 15
`define BFR_SSW_MV 14
`define BFR_SSW_TR 12
`define BFR_SSW_B1 11
`define BFR_SSW_B0 10
`define BFR_SSW_RR 9
`define BFR_SSW_RM 8
`define BFR_SSW_IN 7
`define BFR_SSW_RW 6
`define BFR_SSW_LG 5
`define BFR_SSW_WH 4
`define BFR_SSW_WL 3
`define BFR_SSW_SH 2

// Frame geometry
`define BFR_LAST_WORD 4'hb
`define BFR_FRAME_BYTES 32'h0000_0018
`define BFR_EXC_GAP 32'h0000_0006
`define BFR_CNT_IDX 10
`define BFR_SSW_IDX 11
`define BFR_XFER_FULL 8'h10
`define BFR_FVW_BUS_FAULT_INPUT 16'hc008
`define BFR_FMT_SIX 4'h2

// Bus cycle attributes
`define BFR_SPACE_SUP_DATA 3'h5
`define BFR_SPACE_SUP_PROG 3'h6
`define BFR_WIDTH_LONG 2'h0
`define BFR_WIDTH_WORD 2'h2

`endif

// ==== hdl/bfr_pkg.sv ====
package bfr_pkg;

  // Fault classes as seen by the sequencer
  typedef enum logic [1:0] {
    BFR_RELEASED,
    BFR_ABORTED,
    BFR_BLOCK,
    BFR_EXCEPT
  } bfr_kind_t;

  // Everything the core hands over when a bus fault is taken
  typedef struct packed {
    bfr_kind_t kind;
    logic step_pend;
    logic brk1;
    logic brk0;
    logic rmw;
    logic refetch;
    logic dir;
    logic long_split;
    logic [1:0] width;
    logic [2:0] space;
    logic dyn_sized;
    logic vec_fault;
    logic four_word;
    logic block_dec;
    logic [2:0] op_size;
    logic [4:0] attempts;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] ret_pc;
    logic [31:0] fpc;
    logic [31:0] sp;
    logic [31:0] vbr;
    logic [15:0] sr;
    logic [15:0] pre_sr;
    logic [15:0] faulted_fvw;
  } bfr_fault_t;

  // Machine state given back on exception return
  typedef struct packed {
    logic [31:0] fault_addr;
    logic [31:0] data;
    logic [31:0] pc;
    logic [15:0] sr;
  } bfr_restore_t;

  // Sequencer states
  typedef enum {
    S_IDLE,
    S_STACK,
    S_UNSTACK,
    S_CHECK,
    S_RERUN,
    S_FINISH,
    S_VEC,
    S_REBUILD
  } bfr_state_t;

endpackage

// ==== hdl/bfr_top.sv ====
`timescale 1ns/1ps
`include "bfr_consts.svh"
module bfr_top
  import bfr_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01 // Arbitrary revision code
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Fault entry from the core
  input wire logic fault_i,
  input wire bfr_fault_t fault_info_i,
  output logic stacked_o,
  output logic [31:0] new_sp_o,
  // Exception return from the core
  input wire logic rte_i,
  input wire logic [31:0] rte_sp_i,
  input wire logic [31:0] rte_vbr_i,
  output logic busy_o,
  output logic restore_valid_o,
  output bfr_restore_t restore_o,
  output logic requeue_trace_o,
  output logic requeue_brkpt_o,
  output logic restart_o,
  output logic continue_o,
  output logic [7:0] xfer_count_o,
  output logic [7:0] rescan_count_o,
  output logic resume_o,
  output logic [31:0] resume_pc_o,
  output logic format_error_o,
  // Stack memory port towards the bus controller
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic [2:0] mem_space_o,
  output logic [1:0] mem_width_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);

  // Frame image, shared by stacking and unstacking
  logic [15:0] frame [0:11];
  bfr_state_t state; // Sequencer state
  logic [3:0] idx; // Word index within the frame
  logic [2:0] sub; // Word index for rerun, vector, rebuild
  logic [31:0] base; // Lowest byte address of the frame
  logic [31:0] vbr; // Vector base for the return path
  logic [31:0] handler; // Refetched handler address
  logic enable; // Software enable
  logic rev_err; // Sticky revision mismatch flag

  // Builds one frame word; same order used for unstacking
  function automatic logic [15:0] frame_word(input bfr_fault_t f, input logic [15:0] fault_status_word,
      input logic [31:0] fa, input logic [15:0] cnt, input logic [3:0] i);
    logic [15:0] w;
    logic ex;
    logic ex4;
    w = 16'h0000;
    ex = (f.kind == BFR_EXCEPT);
    ex4 = ex & f.four_word;
    case (i)
      4'h0: w = f.sr;
      4'h1: w = f.ret_pc[31:16];
      4'h2: w = f.ret_pc[15:0];
      4'h3: w = `BFR_FVW_BUS_FAULT_INPUT;
      4'h4: w = fa[31:16];
      4'h5: w = fa[15:0];
      4'h6: w = ex ? f.pre_sr : f.data[31:16];
      4'h7: w = ex ? f.faulted_fvw : f.data[15:0];
      // Short faulted frame has no faulted PC
      4'h8: w = ex4 ? cnt : f.fpc[31:16];
      4'h9: w = ex4 ? fault_status_word : f.fpc[15:0];
      4'ha: w = cnt;
      4'hb: w = fault_status_word;
      default: w = 16'h0000; // Indices 12..15 never used
    endcase
    return w;
  endfunction

  // Which frame word goes to each slot of a rebuilt frame
  function automatic int rb_idx(input logic [2:0] s);
    int r;
    r = 6;
    case (s)
      3'h0: r = 6;
      3'h1: r = 1;
      3'h2: r = 2;
      3'h3: r = 7;
      3'h4: r = 8;
      default: r = 9;
    endcase
    return r;
  endfunction

  // Fault entry decode
  wire bfr_fault_t fi = fault_info_i;
  wire is_exc = (fi.kind == BFR_EXCEPT);
  wire is_blk = (fi.kind == BFR_BLOCK);
  wire is_rel = (fi.kind == BFR_RELEASED);
  wire is_abt = (fi.kind == BFR_ABORTED);
  // Class bits: 00 ordinary, 01 block transfer, 10 exception
  wire new_tp = is_exc;
  wire new_mv = is_blk;
  // Restart clears trace pending: it requeues from SR anyway
  wire new_tr = fi.step_pend & ~is_abt;
  // Released writes always rerun; block faults rerun writes
  wire new_rr = is_rel | (is_blk & ~fi.dir);
  wire new_rm = is_abt & fi.rmw;
  wire new_in = (is_abt | is_blk) & fi.refetch;
  wire [15:0] new_ssw = {new_tp, new_mv, 1'b0, new_tr, fi.brk1, fi.brk0, new_rr,
                         new_rm, new_in, fi.dir, fi.long_split, fi.width,
                         fi.space};
  wire [31:0] op_step = {29'h0, fi.op_size};
  wire [31:0] blk_addr = fi.block_dec ? fi.addr - op_step : fi.addr + op_step;
  wire [31:0] vec_addr = fi.vbr + {20'h0, fi.faulted_fvw[11:0]};
  wire [31:0] dyn_addr = {fi.addr[31:1], 1'b0};
  // Fault address choice by class and cycle kind
  wire [31:0] new_fa = (is_exc & fi.vec_fault) ? vec_addr :
                       is_blk ? blk_addr :
                       fi.dyn_sized ? dyn_addr : fi.addr;
  wire [7:0] left = `BFR_XFER_FULL - {3'h0, fi.attempts};
  wire [15:0] new_cnt = {REVISION, is_blk ? left : 8'h00};
  // Fault frame goes six bytes under the faulted frame
  wire [31:0] top_sp = is_exc ? fi.sp - `BFR_EXC_GAP : fi.sp;
  wire [31:0] new_base = top_sp - `BFR_FRAME_BYTES;

  // Stacked frame decode on return
  wire [15:0] r_ssw = frame[`BFR_SSW_IDX];
  wire [15:0] r_cnt = frame[`BFR_CNT_IDX];
  wire [31:0] r_fa = {frame[4], frame[5]};
  wire [31:0] r_db = {frame[6], frame[7]};
  wire [31:0] r_pc = {frame[1], frame[2]};
  wire rev_ok = (r_cnt[15:8] == REVISION);
  wire [1:0] r_width = r_ssw[`BFR_SSW_WH:`BFR_SSW_WL];
  wire r_long = (r_width == `BFR_WIDTH_LONG);
  wire r_six = (frame[7][15:12] == `BFR_FMT_SIX);
  wire [31:0] r_vec = vbr + {20'h0, frame[7][11:0]};
  wire [31:0] r_top = base + `BFR_FRAME_BYTES + `BFR_EXC_GAP;
  // Six-word or four-word original frame below the old SP
  wire [31:0] rb_base = r_top - (r_six ? 32'h0000_000c : 32'h0000_0008);
  wire [2:0] rb_last = r_six ? 3'h5 : 3'h3;
  wire [2:0] rr_last = r_long ? 3'h1 : 3'h0;
  wire [31:0] sub_off = {28'h0, sub, 1'b0};
  wire [31:0] idx_off = {27'h0, idx, 1'b0};

  // Next memory request, selected by state
  wire st_mem = (state == S_STACK) | (state == S_UNSTACK) | (state == S_RERUN) |
                (state == S_VEC) | (state == S_REBUILD);
  wire issue = st_mem & ~mem_req_o & ~mem_ack_i;
  wire done_ack = mem_req_o & mem_ack_i;
  // Rerun takes address and width from the edited frame
  wire [31:0] rr_addr = r_fa + sub_off;
  wire [15:0] rr_data = (r_long & (sub == 3'h0)) ? r_db[31:16] : r_db[15:0];
  wire [31:0] next_addr = (state == S_RERUN) ? rr_addr :
                          (state == S_VEC) ? r_vec + sub_off :
                          (state == S_REBUILD) ? rb_base + sub_off : base + idx_off;
  // Direction follows the stacked flag, even if edited
  wire next_we = (state == S_RERUN) ? ~r_ssw[`BFR_SSW_RW] :
                 (state == S_STACK) | (state == S_REBUILD);
  wire [15:0] next_wdata = (state == S_RERUN) ? rr_data :
                           (state == S_REBUILD) ? frame[rb_idx(sub)] : frame[idx];
  wire [2:0] next_space = (state == S_RERUN) ? r_ssw[`BFR_SSW_SH:0] :
                          (state == S_VEC) ? `BFR_SPACE_SUP_PROG : `BFR_SPACE_SUP_DATA;
  wire [1:0] next_width = (state == S_RERUN) ? r_width : `BFR_WIDTH_WORD;

  // Wishbone decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire [3:0] wb_off = wb_adr_i[3:0];
  wire wb_hit_ctrl = (wb_adr_i[31:4] == 28'h0) & (wb_off == `BFR_REG_CTRL);
  wire wb_hit_stat = (wb_adr_i[31:4] == 28'h0) & (wb_off == `BFR_REG_STAT);
  wire wb_hit_rev = (wb_adr_i[31:4] == 28'h0) & (wb_off == `BFR_REG_REV);
  wire [31:0] rd_ctrl = {31'h0, enable};
  wire [31:0] rd_stat = {14'h0, r_ssw, rev_err, busy_o};
  wire [31:0] rd_rev = {24'h0, REVISION};
  // Unmapped addresses read as zero and still acknowledge
  wire [31:0] next_rdata = wb_hit_ctrl ? rd_ctrl : wb_hit_stat ? rd_stat :
                           wb_hit_rev ? rd_rev : 32'h0;
  wire clr_rev = wb_wr & wb_hit_stat & wb_dat_i[`BFR_STAT_REVERR];

  // Wishbone slave: one-cycle registered answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      enable <= `BFR_CTRL_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= next_rdata;
      end
      if (wb_wr & wb_hit_ctrl) begin
        enable <= wb_dat_i[`BFR_CTRL_EN];
      end
    end
  end

  // Sticky mismatch flag; a new mismatch beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rev_err <= 1'b0;
    end else if (format_error_o) begin
      rev_err <= 1'b1;
    end else if (clr_rev) begin
      rev_err <= 1'b0;
    end
  end

  // Memory request: held until ack, then one idle cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0;
      mem_wdata_o <= 16'h0;
      mem_space_o <= 3'h0;
      mem_width_o <= 2'h0;
    end else if (done_ack) begin
      mem_req_o <= 1'b0;
    end else if (issue) begin
      mem_req_o <= 1'b1;
      mem_we_o <= next_we;
      mem_addr_o <= next_addr;
      mem_wdata_o <= next_wdata;
      mem_space_o <= next_space;
      mem_width_o <= next_width;
    end
  end

  // Frame image: loaded at fault entry, filled while unstacking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 12; k++) begin
        frame[k] <= 16'h0;
      end
    end else if ((state == S_IDLE) & enable & fault_i) begin
      for (int k = 0; k < 12; k++) begin
        frame[k] <= frame_word(fi, new_ssw, new_fa, new_cnt, 4'(k));
      end
    end else if ((state == S_UNSTACK) & done_ack) begin
      frame[idx] <= mem_rdata_i;
    end
  end

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      idx <= 4'h0;
      sub <= 3'h0;
      base <= 32'h0;
      vbr <= 32'h0;
      handler <= 32'h0;
      busy_o <= 1'b0;
      stacked_o <= 1'b0;
      new_sp_o <= 32'h0;
      restore_valid_o <= 1'b0;
      restore_o <= '0;
      requeue_trace_o <= 1'b0;
      requeue_brkpt_o <= 1'b0;
      restart_o <= 1'b0;
      continue_o <= 1'b0;
      xfer_count_o <= 8'h0;
      rescan_count_o <= 8'h0;
      resume_o <= 1'b0;
      resume_pc_o <= 32'h0;
      format_error_o <= 1'b0;
    end else begin
      // Event outputs are one-cycle pulses
      stacked_o <= 1'b0;
      restore_valid_o <= 1'b0;
      requeue_trace_o <= 1'b0;
      requeue_brkpt_o <= 1'b0;
      restart_o <= 1'b0;
      continue_o <= 1'b0;
      resume_o <= 1'b0;
      format_error_o <= 1'b0;
      unique case (state)
        S_IDLE: begin
          idx <= 4'h0;
          sub <= 3'h0;
          // Fault entry wins if both arrive together
          if (enable & fault_i) begin
            base <= new_base;
            busy_o <= 1'b1;
            state <= S_STACK;
          end else if (enable & rte_i) begin
            base <= rte_sp_i;
            vbr <= rte_vbr_i;
            busy_o <= 1'b1;
            state <= S_UNSTACK;
          end
        end
        S_STACK: begin
          // Twelve word writes, lowest address first
          if (done_ack) begin
            idx <= idx + 4'h1;
            if (idx == `BFR_LAST_WORD) begin
              stacked_o <= 1'b1;
              new_sp_o <= base;
              busy_o <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_UNSTACK: begin
          if (done_ack) begin
            idx <= idx + 4'h1;
            if (idx == `BFR_LAST_WORD) begin
              state <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          sub <= 3'h0;
          // Foreign revision: nothing is restored
          if (!rev_ok) begin
            format_error_o <= 1'b1;
            busy_o <= 1'b0;
            state <= S_IDLE;
          end else if (r_ssw[`BFR_SSW_TP]) begin
            state <= S_VEC;
          end else begin
            restore_o <= '{fault_addr: r_fa, data: r_db, pc: r_pc, sr: frame[0]};
            restore_valid_o <= 1'b1;
            requeue_trace_o <= r_ssw[`BFR_SSW_TR];
            requeue_brkpt_o <= r_ssw[`BFR_SSW_B1] | r_ssw[`BFR_SSW_B0];
            // Only the rerun flag decides on a rerun
            state <= r_ssw[`BFR_SSW_RR] ? S_RERUN : S_FINISH;
          end
        end
        S_RERUN: begin
          // Read data returned here is never captured
          if (done_ack) begin
            sub <= sub + 3'h1;
            if (sub == rr_last) begin
              state <= S_FINISH;
            end
          end
        end
        S_FINISH: begin
          // Continue keeps the stacked address, no recompute
          if (r_ssw[`BFR_SSW_MV]) begin
            continue_o <= 1'b1;
            xfer_count_o <= r_cnt[7:0];
            rescan_count_o <= `BFR_XFER_FULL - r_cnt[7:0];
          end else begin
            // Transfers already done are simply repeated
            restart_o <= 1'b1;
          end
          resume_pc_o <= r_pc;
          busy_o <= 1'b0;
          state <= S_IDLE;
        end
        S_VEC: begin
          // Handler address fetched high word first
          if (done_ack) begin
            sub <= sub + 3'h1;
            if (sub == 3'h0) begin
              handler[31:16] <= mem_rdata_i;
            end else begin
              handler[15:0] <= mem_rdata_i;
              sub <= 3'h0;
              state <= S_REBUILD;
            end
          end
        end
        S_REBUILD: begin
          // Original frame rewritten, then resume at handler
          if (done_ack) begin
            sub <= sub + 3'h1;
            if (sub == rb_last) begin
              resume_o <= 1'b1;
              resume_pc_o <= handler;
              new_sp_o <= rb_base;
              busy_o <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule

// ==== tb/bfr_top_chk.sv ====
`timescale 1ns/1ps
module bfr_top_chk
  import bfr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Sequencer results
  input wire logic stacked_o,
  input wire logic restore_valid_o,
  input wire logic requeue_trace_o,
  input wire logic requeue_brkpt_o,
  input wire logic restart_o,
  input wire logic continue_o,
  input wire logic resume_o,
  input wire logic format_error_o,
  // Stack memory port
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Request still waiting for its answer
  sequence s_mem_wait;
    mem_req_o && !mem_ack_i;
  endsequence
  // Request and its address, direction and write data unchanged
  sequence s_mem_held;
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o);
  endsequence
  // Restart, continue or resume pulse at the end of a return
  sequence s_done;
    restart_o || continue_o || resume_o;
  endsequence

  a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered next cycle");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_mem_hold: assert property (s_mem_wait |=> s_mem_held)
    else $error("stack request changed before ack");
  a_mem_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("stack request kept after ack");
  a_stack_pulse: assert property (stacked_o |=> !stacked_o)
    else $error("frame done pulse too long");
  a_requeue_with: assert property (requeue_trace_o || requeue_brkpt_o |-> restore_valid_o)
    else $error("requeue without restore");
  a_format_alone: assert property (format_error_o |-> !restore_valid_o && !(restart_o || continue_o || resume_o))
    else $error("restore despite revision mismatch");
  a_end_quiet: assert property (s_done |-> !mem_req_o ##1 !(restart_o || continue_o || resume_o))
    else $error("return end pulse overlaps traffic");
  a_restart_excl: assert property (restart_o |-> !continue_o)
    else $error("restart and continue together");
endmodule

bind bfr_top bfr_top_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .stacked_o,
  .restore_valid_o, .requeue_trace_o, .requeue_brkpt_o, .restart_o, .continue_o, .resume_o,
  .format_error_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i);

// ==== tb/bfr_top_tb.sv ====
`timescale 1ns/1ps
module bfr_top_tb;
  import bfr_pkg::*;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary revision code
  // Stimulus
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic fault_i = 1'h0;
  bfr_fault_t fault_info_i = '0;
  logic rte_i = 1'h0;
  logic [31:0] rte_sp_i = 32'h0;
  logic [31:0] rte_vbr_i = 32'h0;
  logic mem_ack_i = 1'h0;
  logic [15:0] mem_rdata_i = 16'h0;
  // Observed outputs
  logic [31:0] wb_dat_o, new_sp_o, resume_pc_o, mem_addr_o;
  logic wb_ack_o, stacked_o, busy_o, restore_valid_o, requeue_trace_o, requeue_brkpt_o;
  logic restart_o, continue_o, resume_o, format_error_o, mem_req_o, mem_we_o;
  bfr_restore_t restore_o;
  logic [7:0] xfer_count_o, rescan_count_o;
  logic [15:0] mem_wdata_o;
  logic [2:0] mem_space_o;
  logic [1:0] mem_width_o;
  // Bench state
  logic [15:0] mem [logic [31:0]]; // Sparse stack image
  int seed = 78;
  int n_fail = 0;
  int num_checks = 0;
  int n_wr = 0;
  int dly = 0;
  logic got_rv, got_tr, got_bk, got_rs, got_ct, got_res, got_fe;
  bfr_restore_t rv_q;
  logic [7:0] xc_q, rs_q;
  logic [31:0] pc_q;
  logic [4:0] attr_q = 5'h0; // Space and width of the last acked access

  bfr_top #(.REVISION(REV)) dut_u (.*);

  // Core clock
  always #25 clk_i = ~clk_i;

  // Stack responder with random wait states
  always @(posedge clk_i) begin
    if (mem_req_o && !mem_ack_i && dly == 0) begin
      mem_ack_i <= 1'h1;
      dly <= {$random(seed)} % 3;
      attr_q <= {mem_space_o, mem_width_o};
      if (mem_we_o) begin
        mem[mem_addr_o] = mem_wdata_o;
        n_wr++;
        mem_rdata_i <= 16'($random(seed));
      end else begin
        mem_rdata_i <= mem.exists(mem_addr_o) ? mem[mem_addr_o] : 16'h0;
      end
    end else begin
      // Junk outside answers
      mem_ack_i <= 1'h0;
      mem_rdata_i <= 16'($random(seed));
      if (mem_req_o && !mem_ack_i) dly <= dly - 1;
    end
  end

  // Hang guard, generous for the whole run
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end

  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Unwritten words read as unknown so they never match
  function automatic logic [15:0] rd(input logic [31:0] a);
    rd = mem.exists(a) ? mem[a] : 16'hxxxx;
  endfunction

  function automatic void wr32(input logic [31:0] a, input logic [31:0] d);
    mem[a] = d[31:16];
    mem[a + 32'h2] = d[15:0];
  endfunction

  // Expected status word image
  function automatic logic [15:0] exp_ssw(input bfr_fault_t f);
    exp_ssw = {f.kind == BFR_EXCEPT, f.kind == BFR_BLOCK, 1'h0, f.step_pend, f.brk1, f.brk0,
      f.kind == BFR_RELEASED || (f.kind == BFR_BLOCK && !f.dir), f.rmw, f.refetch, f.dir,
      f.long_split, f.width, f.space};
  endfunction

  // Expected stacked fault address
  function automatic logic [31:0] exp_fa(input bfr_fault_t f);
    if (f.kind == BFR_BLOCK) begin
      exp_fa = f.block_dec ? f.addr - 32'(f.op_size) : f.addr + 32'(f.op_size);
    end else begin
      exp_fa = f.dyn_sized ? {f.addr[31:1], 1'h0} : f.addr;
    end
  endfunction

  // Random fault of one class, kept within what the core could report
  function automatic bfr_fault_t mk(input bfr_kind_t k);
    bfr_fault_t f;
    f = '0;
    f.kind = k;
    {f.addr, f.data, f.ret_pc, f.fpc, f.sr, f.pre_sr} = {$random(seed), $random(seed),
      $random(seed), $random(seed), $random(seed)};
    {f.brk1, f.brk0, f.long_split, f.block_dec, f.width, f.space} = 9'($random(seed));
    f.step_pend = (k != BFR_ABORTED) && f.pre_sr[0];
    f.dir = (k == BFR_EXCEPT) || (k != BFR_RELEASED && f.fpc[0]);
    f.rmw = (k == BFR_ABORTED) && f.fpc[1];
    f.refetch = (k == BFR_ABORTED || k == BFR_BLOCK) && f.fpc[18];
    f.dyn_sized = (k == BFR_RELEASED || k == BFR_ABORTED) && f.fpc[2];
    f.addr[0] = f.dyn_sized && f.addr[0];
    f.ret_pc[0] = 1'h0;
    f.op_size = f.fpc[3] ? 3'h4 : 3'h2;
    f.attempts = 5'h1 + 5'(f.fpc[7:4]);
    f.faulted_fvw = {f.fpc[8] ? 4'h2 : 4'h0, 2'h0, f.fpc[17:10], 2'h0};
    f.four_word = !f.fpc[8];
    f.sp = 32'h8000;
    f.vbr = 32'h1000;
    if (k == BFR_EXCEPT && f.fpc[9]) begin
      f.vec_fault = 1'h1;
      f.addr = f.vbr + 32'(f.faulted_fvw[11:0]);
    end
    mk = f;
  endfunction

  // Classic single Wishbone cycle
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (n >= 50) n_fail++;
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic take_fault(input bfr_fault_t f);
    int n;
    @(posedge clk_i);
    fault_i <= 1'h1;
    fault_info_i <= f;
    @(posedge clk_i);
    fault_i <= 1'h0;
    n = 0;
    while (stacked_o !== 1'h1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) n_fail++;
  endtask

  // Return; one-cycle results are caught at the edge they stand
  task automatic do_rte(input logic [31:0] sp, input logic [31:0] vbr);
    int n;
    int idle;
    {got_rv, got_tr, got_bk, got_rs, got_ct, got_res, got_fe} = '0;
    n_wr = 0;
    @(posedge clk_i);
    rte_i <= 1'h1;
    rte_sp_i <= sp;
    rte_vbr_i <= vbr;
    @(posedge clk_i);
    rte_i <= 1'h0;
    n = 0;
    idle = 0;
    while ((busy_o === 1'h1 || idle < 3) && n < 400) begin
      @(posedge clk_i);
      n++;
      idle = busy_o ? 0 : idle + 1;
      if (restore_valid_o) begin
        got_rv = 1'h1;
        rv_q = restore_o;
        got_tr = requeue_trace_o;
        got_bk = requeue_brkpt_o;
      end
      if (restart_o || resume_o) pc_q = resume_pc_o;
      if (continue_o) {xc_q, rs_q} = {xfer_count_o, rescan_count_o};
      got_rs |= restart_o;
      got_ct |= continue_o;
      got_res |= resume_o;
      got_fe |= format_error_o;
    end
    if (n >= 400) n_fail++;
  endtask

  initial begin
    bfr_fault_t f;
    logic [31:0] q, base, fa;
    int k;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 32'h0, 32'h0, q);
    chk(q, 32'h1);
    wb(1'h0, 32'h8, 32'h0, q);
    chk(q, {24'h0, REV});
    wb(1'h0, 32'h3c, 32'h0, q);
    chk(q, 32'h0);
    for (k = 0; k < 16; k++) begin
      f = mk(bfr_kind_t'(k % 4));
      take_fault(f);
      base = f.sp - ((f.kind == BFR_EXCEPT) ? 32'h1e : 32'h18);
      fa = exp_fa(f);
      chk(new_sp_o, base);
      chk(rd(base + 32'h6), 16'hc008);
      chk(rd(base + 32'h16), exp_ssw(f));
      chk(rd(base + 32'h14), {REV, f.kind == BFR_BLOCK ? 8'h10 - 8'(f.attempts) : 8'h0});
      chk({rd(base + 32'h8), rd(base + 32'ha)}, fa);
      chk({rd(base + 32'h2), rd(base + 32'h4)}, f.ret_pc);
      chk(attr_q, 5'h16);
      if (f.kind == BFR_EXCEPT && f.four_word) chk({rd(base + 32'h10), rd(base + 32'h12)}, {REV, 8'h0, exp_ssw(f)});
      wb(1'h0, 32'h4, 32'h0, q);
      chk(q[17:2], exp_ssw(f));
      case (f.kind)
        BFR_RELEASED: begin
          // Handler widens the split write back to a whole long
          wr32(base + 32'h8, fa - 32'h2);
          mem[base + 32'h16][4:3] = 2'h0;
          do_rte(base, 32'h0);
          chk(rv_q.fault_addr, fa - 32'h2);
          chk({rd(fa - 32'h2), rd(fa)}, f.data);
          chk(attr_q, {f.space, 2'h0});
        end
        BFR_ABORTED: begin
          do_rte(base, 32'h0);
          chk({got_rs, 32'(n_wr)}, 33'h1_0000_0000);
          chk(pc_q, f.ret_pc);
        end
        BFR_BLOCK: begin
          if (k[3]) mem[base + 32'h16][14] = 1'h0;
          do_rte(base, 32'h0);
          chk({got_ct, got_rs}, {!k[3], k[3]});
          if (!k[3]) chk({xc_q, rs_q}, {8'h10 - 8'(f.attempts), 8'(f.attempts)});
        end
        default: begin
          wr32(f.vbr + 32'(f.faulted_fvw[11:0]), f.data);
          do_rte(base, f.vbr);
          chk({got_res, got_rv, pc_q}, {2'h2, f.data});
          base = f.sp - (f.four_word ? 32'h8 : 32'hc);
          chk(new_sp_o, base);
          chk({rd(base), rd(base + 32'h6)}, {f.pre_sr, f.faulted_fvw});
          chk({rd(base + 32'h2), rd(base + 32'h4)}, f.ret_pc);
        end
      endcase
      if (f.kind != BFR_EXCEPT) begin
        chk(got_rv, 1'h1);
        chk({rv_q.sr, rv_q.pc}, {f.sr, f.ret_pc});
        chk(rv_q.data, f.data);
        chk({got_tr, got_bk}, {f.step_pend, f.brk1 | f.brk0});
      end
    end
    // Foreign revision in the frame is refused
    f = mk(BFR_ABORTED);
    take_fault(f);
    mem[new_sp_o + 32'h14][15:8] = ~REV;
    do_rte(new_sp_o, 32'h0);
    chk({got_fe, got_rv, got_rs}, 3'h4);
    wb(1'h0, 32'h4, 32'h0, q);
    chk(q[1], 1'h1);
    wb(1'h1, 32'h4, 32'h2, q);
    wb(1'h0, 32'h4, 32'h0, q);
    chk(q[1:0], 2'h0);
    // Disabled block ignores faults
    wb(1'h1, 32'h0, 32'h0, q);
    n_wr = 0;
    @(posedge clk_i);
    fault_i <= 1'h1;
    @(posedge clk_i);
    fault_i <= 1'h0;
    repeat (30) @(posedge clk_i);
    chk({busy_o, 32'(n_wr)}, 33'h0);
    complete_run();
  end
endmodule
